// *** adc_port_pkg.sv ***
`default_nettype none

package adc_port_pkg;

    // Resolution of the result word.
    localparam int RESULT_WIDTH = 8;

    // Cycles from the sampling edge to the result on the output pins.
    localparam int PIPELINE_LATENCY = 6;

    // Saturated codes for inputs outside the reference span.
    localparam logic [7:0] CODE_ALL_ZERO = 8'h00;
    localparam logic [7:0] CODE_ALL_ONE = 8'hff;

    // Output word after reset, before the first result arrives.
    localparam logic [7:0] OUTPUT_RESET_VALUE = 8'h00;

    // Clock period in picoseconds.
    localparam int CLOCK_PERIOD_PS = 5000;

    // Settling time after leaving sleep, kept for the capturing side.
    localparam int WAKE_SETTLE_US = 1000;
    localparam int WAKE_SETTLE_CYCLES = (WAKE_SETTLE_US * 1000000) / CLOCK_PERIOD_PS;

endpackage

`default_nettype wire

// *** adc_pipe_stage.sv ***
`default_nettype none

module adc_pipe_stage #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Stage data.
    input wire logic advance_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    always_comb
    begin
        data_next = data_reg;
        if (advance_i)
        begin
            data_next = data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_reg <= '0;
        end
        else
        begin
            data_reg <= data_next;
        end
    end

    assign data_o = data_reg;

endmodule

`default_nettype wire

// *** adc_output_port.sv ***
`default_nettype none

// Behaviour
// - A sample is taken at every rising clock edge while converting.
// - A sample's result reaches the output pins six cycles after its sampling edge.
// - A fresh result word leaves every converting clock cycle, in order; words in flight across a sleep leave later than the fixed latency.
// - An input below the bottom reference level gives an all-zero word.
// - An input above the top reference level gives an all-one word.
// - Conversion runs on clock edges alone; no start trigger exists.
// - The block converts while sleep request is low; the controller drives it low.
// - While sleep request is high, conversion stops and outputs hold the last result.
// - With the clock stopped the output word simply keeps its last value.

module adc_output_port #(
    parameter int WIDTH = adc_port_pkg::RESULT_WIDTH,
    parameter int LATENCY = adc_port_pkg::PIPELINE_LATENCY
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Quantiser result for the current edge, with range flags.
    input wire logic [WIDTH-1:0] sample_code_i,
    input wire logic below_bottom_reference_level_i,
    input wire logic above_top_reference_level_i,
    // Power control pin.
    input wire logic sleep_request_i,
    // Parallel output pins.
    output logic [WIDTH-1:0] result_o,
    output logic converting_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Sleep pin synchroniser. The pin comes from outside the clock domain.

    logic sleep_meta_reg;
    logic sleep_sync_reg;
    logic sleep_meta_next;
    logic sleep_sync_next;

    always_comb
    begin
        sleep_meta_next = sleep_request_i;
        sleep_sync_next = sleep_meta_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
        end
        else
        begin
            sleep_meta_reg <= sleep_meta_next;
            sleep_sync_reg <= sleep_sync_next;
        end
    end

    // Active only while the synchronised sleep request is low.
    logic active;
    assign active = ~sleep_sync_reg;
    assign converting_o = active;

    ////////////////////////////////////////////////////////////////////////////
    // Sampling and range saturation.

    // Saturation is applied before the pipeline so the clamp costs no latency.
    logic [WIDTH-1:0] sample_word;

    always_comb
    begin
        sample_word = sample_code_i;
        if (below_bottom_reference_level_i)
        begin
            sample_word = {WIDTH{1'b0}};
        end
        else if (above_top_reference_level_i)
        begin
            sample_word = {WIDTH{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline. The last stage is the output register, so LATENCY stages give
    // the result LATENCY edges after its sampling edge. Stages freeze together
    // in sleep, which holds the output word without any extra hold register.

    logic [WIDTH-1:0] stage_data [0:LATENCY];

    assign stage_data[0] = sample_word;

    generate
        for (genvar i = 0; i < LATENCY; i++)
        begin : g_stage
            adc_pipe_stage #(
                .WIDTH(WIDTH)
            ) u_stage (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .advance_i(active),
                .data_i(stage_data[i]),
                .data_o(stage_data[i+1])
            );
        end
    endgenerate

    // Registered output; without clock edges it cannot change.
    assign result_o = stage_data[LATENCY];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [WIDTH-1:0] sat_word;
    assign sat_word = sample_word;

    // Consecutive converting edges since reset or sleep, saturating at the
    // pipeline depth. A word left in flight by a reset or a sleep is older than
    // the depth suggests, so the stream check must not compare it.
    localparam int STREAK_W = $clog2(LATENCY + 1);
    localparam logic [STREAK_W-1:0] STREAK_FULL = STREAK_W'(LATENCY);

    logic [STREAK_W-1:0] streak_reg;
    logic [STREAK_W-1:0] streak_next;

    always_comb
    begin
        streak_next = streak_reg;
        if (!active)
        begin
            streak_next = '0;
        end
        else if (streak_reg != STREAK_FULL)
        begin
            streak_next = streak_reg + STREAK_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            streak_reg <= '0;
        end
        else
        begin
            streak_reg <= streak_next;
        end
    end

    sequence s_sample_taken;
        active;
    endsequence

    // The counts below are written for the documented depth of six stages.
    sequence s_sample_carried;
        active [*5];
    endsequence

    property p_latency;
        @(posedge clk_i) disable iff (rst_i)
        s_sample_taken ##1 s_sample_carried |=> result_o == $past(sample_word, 6);
    endproperty
    a_latency: assert property (p_latency) else $error("result not six cycles after sample");

    property p_six_cycle;
        @(posedge clk_i) disable iff (rst_i)
        (streak_reg == STREAK_FULL) |-> result_o == $past(sample_word, LATENCY);
    endproperty
    a_six_cycle: assert property (p_six_cycle) else $error("word stream out of step");

    property p_low_clamp;
        @(posedge clk_i) disable iff (rst_i)
        below_bottom_reference_level_i |-> sat_word == adc_port_pkg::CODE_ALL_ZERO;
    endproperty
    a_low_clamp: assert property (p_low_clamp) else $error("underrange not all zero");

    property p_high_clamp;
        @(posedge clk_i) disable iff (rst_i)
        (above_top_reference_level_i && !below_bottom_reference_level_i)
        |-> sat_word == adc_port_pkg::CODE_ALL_ONE;
    endproperty
    a_high_clamp: assert property (p_high_clamp) else $error("overrange not all one");

    property p_low_out;
        @(posedge clk_i) disable iff (rst_i)
        (below_bottom_reference_level_i && active) ##1 s_sample_carried
        |=> result_o == adc_port_pkg::CODE_ALL_ZERO;
    endproperty
    a_low_out: assert property (p_low_out) else $error("underrange word not zero at pins");

    property p_high_out;
        @(posedge clk_i) disable iff (rst_i)
        (above_top_reference_level_i && !below_bottom_reference_level_i && active) ##1 s_sample_carried
        |=> result_o == adc_port_pkg::CODE_ALL_ONE;
    endproperty
    a_high_out: assert property (p_high_out) else $error("overrange word not all one at pins");

    property p_sleep_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!active && !$past(rst_i)) |=> $stable(result_o);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("output moved during sleep");

    property p_sleep_enter;
        @(posedge clk_i) disable iff (rst_i)
        $rose(sleep_request_i) |-> ##2 !converting_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered in two cycles");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        ($fell(sleep_request_i) ##1 !sleep_request_i) |-> ##1 converting_o;
    endproperty
    a_wake: assert property (p_wake) else $error("conversion not resumed after wake");

    property p_advance;
        @(posedge clk_i) disable iff (rst_i)
        (active && !$past(rst_i)) |=> stage_data[1] == $past(sample_word);
    endproperty
    a_advance: assert property (p_advance) else $error("sample not taken on active edge");

endmodule

`default_nettype wire

// *** adc_capture.sv ***
`default_nettype none

module adc_capture #(
    parameter int SETTLE = 16
) (
    // Converter side.
    input wire logic clk_i,
    input wire logic converting_i,
    input wire logic [7:0] word_i,
    // User side.
    output logic [7:0] word_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int quiet_reg = 0;
    // Words after a wake are distrusted; the span is shortened to keep runs brief.
    always_ff @(posedge clk_i)
    begin
        word_o <= word_i;
        quiet_reg <= !converting_i ? SETTLE : (quiet_reg > 0) ? quiet_reg - 1 : 0;
        valid_o <= converting_i && (quiet_reg == 0);
    end
endmodule

`default_nettype wire

// *** testbench.sv ***
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic clk_en = 1'b1;
    logic rst_i = 1'b1;
    logic started = 1'b0;
    logic [7:0] code = 8'h00;
    logic lo = 1'b0;
    logic hi = 1'b0;
    logic sleep = 1'b0;
    logic [7:0] result_o;
    logic converting_o;
    logic [7:0] word;
    logic valid;
    logic [7:0] held;
    logic [7:0] exp_last = 8'h00;
    logic [7:0] exp_q [6];
    logic slp_meta = 1'b0;
    logic slp_sync = 1'b0;
    int fails = 0;
    int comparisons = 0;

    always #2.5 if (clk_en) clk_i = ~clk_i;

    adc_output_port dut (.clk_i(clk_i), .rst_i(rst_i), .sample_code_i(code),
        .below_bottom_reference_level_i(lo), .above_top_reference_level_i(hi),
        .sleep_request_i(sleep), .result_o(result_o), .converting_o(converting_o));
    adc_capture cap (.clk_i(clk_i), .converting_i(converting_o), .word_i(result_o),
        .word_o(word), .valid_o(valid));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] clamp(logic [7:0] c, logic b, logic a);
        return b ? adc_port_pkg::CODE_ALL_ZERO : a ? adc_port_pkg::CODE_ALL_ONE : c;
    endfunction

    task automatic check(logic ok, string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Inputs change one nanosecond after each rising edge.
    task automatic drive(logic [7:0] c, logic b, logic a);
        @(posedge clk_i);
        #1;
        code = c;
        lo = b;
        hi = a;
    endtask

    // Both range flags together must give the all-zero word.
    task automatic run(int n);
        int r;
        repeat (n)
        begin
            r = $urandom % 8;
            drive(8'($urandom), (r == 0) || (r == 2), (r == 1) || (r == 2));
        end
    endtask

    // Reference model, updated between edges. The two sleep flags follow the
    // pin through a two-stage synchroniser, so the model needs no design output.
    always @(negedge clk_i)
    begin
        if (!rst_i && started)
        begin
            check(result_o === exp_q[5], "result word");
            check(converting_o === !slp_sync, "converting flag");
        end
        if (rst_i)
        begin
            exp_q = '{default: adc_port_pkg::OUTPUT_RESET_VALUE};
            slp_meta = 1'b0;
            slp_sync = 1'b0;
        end
        else
        begin
            exp_last = exp_q[5];
            if (!slp_sync)
            begin
                for (int i = 5; i > 0; i--)
                    exp_q[i] = exp_q[i-1];
                exp_q[0] = clamp(code, lo, hi);
            end
            slp_sync = slp_meta;
            slp_meta = sleep;
        end
    end

    initial
    begin
        void'($urandom(32'hcfef));
        repeat (6) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        started = 1'b1;
        drive(8'h5a, 1'b1, 1'b0);
        drive(8'hff, 1'b1, 1'b1);
        drive(8'h00, 1'b0, 1'b1);
        drive(8'hff, 1'b0, 1'b0);
        drive(8'h00, 1'b0, 1'b0);
        run(300);
        sleep = 1'b1;
        run(1);
        check(converting_o === 1'b1, "sleep taken early");
        run(1);
        check(converting_o === 1'b0, "sleep not taken");
        held = result_o;
        run(20);
        check(result_o === held, "word not frozen");
        sleep = 1'b0;
        for (int n = 0; n < 4 && converting_o !== 1'b1; n++)
            run(1);
        if (converting_o !== 1'b1)
        begin
            check(1'b0, "no wake");
        end
        else
        begin
            check(valid === 1'b0, "capture trusted too early");
            run(40);
            check(valid === 1'b1 && word === exp_last, "capture after settle");
            @(negedge clk_i);
            held = result_o;
            clk_en = 1'b0;
            #50;
            check(result_o === held, "word lost with clock stopped");
            clk_en = 1'b1;
            run(30);
            rst_i = 1'b1;
            run(2);
            check(result_o === adc_port_pkg::OUTPUT_RESET_VALUE && converting_o === 1'b1, "reset");
            rst_i = 1'b0;
            run(200);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
